/* File: rtl/dmc_pkg.sv */
// Constants, types and timing counts for the 64K x 1 dynamic memory controller.
// Assumes a 40 MHz controller clock and one memory part on the strobe pins.
//
// Functional notes
// - Row address latched on row strobe fall.
// - Column address latched on column strobe fall.
// - Write enable high reads, low writes.
// - Early write keeps data output off.
// - Read-write waits column and row delays.
// - Column strobe within row-to-column window.
// - Random cycle time and row width kept.
// - Read-write cycle time before next row.
// - Page mode holds row, repeats columns.
// - Column precharge kept between page cycles.
// - All 128 rows refreshed within 2 ms.
// - Hidden refresh keeps read data valid; refresh here is row-strobe-only from idle, with the data output off.
// - Write enable read setup and hold.
// - Write enable lead before strobes rise.
package dmc_pkg;
   // ---------------------------------------------------------------
   // Timing in nanoseconds (slower grade) and derived cycle counts
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS        = 25;
   localparam int ROW_ADDRESS_HOLD_NS  = 20;
   localparam int ROW_TO_COLUMN_MIN_NS = 30;
   localparam int COLUMN_ACCESS_NS     = 135;
   localparam int ROW_ACCESS_NS        = 200;
   localparam int ROW_STROBE_LOW_NS    = 200;
   localparam int ROW_PRECHARGE_NS     = 120;
   localparam int RANDOM_CYCLE_NS      = 330;
   localparam int READ_WRITE_CYCLE_NS  = 375;
   localparam int PAGE_CYCLE_NS        = 225;
   localparam int PAGE_PRECHARGE_NS    = 80;
   localparam int COL_TO_WRITE_NS      = 95;
   localparam int ROW_TO_WRITE_NS      = 160;
   localparam int WRITE_LEAD_NS        = 80;
   localparam int READ_HOLD_ROW_NS     = 25;
   localparam int RETENTION_NS         = 2000000;
   localparam int REFRESH_ROWS         = 128;

   // Least times round up to whole cycles.
   localparam int RAH_CYC  = (ROW_ADDRESS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RCD_CYC  = (ROW_TO_COLUMN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAC_CYC  = (COLUMN_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RAS_CYC  = (ROW_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC   = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_CYC   = (RANDOM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RWC_CYC  = (READ_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PC_CYC   = (PAGE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CP_CYC   = (PAGE_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CWD_CYC  = (COL_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RWD_CYC  = (ROW_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WL_CYC   = (WRITE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RRH_CYC  = (READ_HOLD_ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time rounds down; spare margin covers a full refresh cycle.
   localparam int REF_INTERVAL_CYC = RETENTION_NS / CLK_PERIOD_NS / REFRESH_ROWS - RC_CYC;

   localparam int CNT_W = 8;
   localparam logic [6:0] ROW_LAST = 7'h7F;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {DMC_READ, DMC_WRITE, DMC_RMW} dmc_op_t;

   typedef struct packed {
      dmc_op_t     op;
      logic [15:0] addr;  // Row in the upper byte, column in the lower.
      logic        wdata;
      logic        page;  // Keep the row open for a following request.
   } dmc_req_t;

   typedef struct packed {
      logic       row_strobe_n;
      logic       col_strobe_n;
      logic       write_en_n;
      logic [7:0] multiplexed_address_pins;
      logic       data_in;
   } dmc_pins_t;
endpackage

/* File: rtl/dmc_ctrl.sv */
// Controller that sequences the strobes of one 64K x 1 dynamic memory.
// Assumes pins are sampled and driven synchronously on the 40 MHz clock.
`timescale 1ns/1ps
module dmc_ctrl #(
   parameter int REF_INTERVAL = dmc_pkg::REF_INTERVAL_CYC
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              arst_n,
   // Host request and answer
   input  wire logic              req_valid,
   input  wire dmc_pkg::dmc_req_t req,
   output logic                   req_ready,
   output logic                   rdata_valid,
   output logic                   rdata,
   // Memory pins
   output dmc_pkg::dmc_pins_t     pins,
   input  wire logic              data_out
);
   import dmc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ROW, ST_COL, ST_ACCESS, ST_WRITE, ST_PAGE_PRE, ST_CLOSE,
      ST_PRECHARGE, ST_REF_ROW
   } dmc_state_t;

   dmc_state_t  state_reg;
   dmc_pins_t   pins_reg;
   dmc_req_t    cur_reg;
   logic [CNT_W-1:0] cnt_reg;     // Cycles in the current state.
   logic [CNT_W-1:0] ras_cnt_reg; // Cycles since the row strobe fell.
   logic [CNT_W-1:0] col_cnt_reg; // Cycles since the column strobe fell.
   logic [CNT_W-1:0] min_cyc_reg; // Least row cycle for this access.
   logic [31:0] ref_timer_reg;
   logic        ref_pend_reg;
   logic [6:0]  ref_row_reg;
   logic        req_ready_reg;
   logic        rdata_valid_reg;
   logic        rdata_reg;
   logic        take;

   assign pins        = pins_reg;
   assign req_ready   = req_ready_reg;
   assign rdata_valid = rdata_valid_reg;
   assign rdata       = rdata_reg;
   assign take        = req_ready_reg && req_valid;

   // ---------------------------------------------------------------
   // Refresh timer and row counter
   // ---------------------------------------------------------------
   // The timer paces one row per slot so all rows recur within retention.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ref_timer_reg <= 32'h0;
         ref_pend_reg  <= 1'b0;
      end else begin
         if (ref_timer_reg >= 32'(REF_INTERVAL - 1)) begin
            ref_timer_reg <= 32'h0;
            ref_pend_reg  <= 1'b1;
         end else begin
            ref_timer_reg <= ref_timer_reg + 32'h1;
            if (state_reg == ST_REF_ROW && cnt_reg == CNT_W'(0))
               ref_pend_reg <= 1'b0;
         end
      end
   end

   // Row counter wraps after the last row; the eighth address bit is zero.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         ref_row_reg <= 7'h00;
      else if (state_reg == ST_REF_ROW && cnt_reg == CNT_W'(0))
         ref_row_reg <= (ref_row_reg == ROW_LAST) ? 7'h00 : ref_row_reg + 7'h01;
   end

   // ---------------------------------------------------------------
   // Strobe sequencer
   // ---------------------------------------------------------------
   // One counter per state keeps every edge spacing an exact cycle figure.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg       <= ST_IDLE;
         pins_reg        <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_en_n: 1'b1,
                              multiplexed_address_pins: 8'h00, data_in: 1'b0};
         cur_reg         <= '0;
         cnt_reg         <= '0;
         ras_cnt_reg     <= '0;
         col_cnt_reg     <= '0;
         min_cyc_reg     <= '0;
         req_ready_reg   <= 1'b0;
         rdata_valid_reg <= 1'b0;
         rdata_reg       <= 1'b0;
      end else begin
         rdata_valid_reg <= 1'b0;
         cnt_reg         <= cnt_reg + CNT_W'(1);
         if (!pins_reg.row_strobe_n)
            ras_cnt_reg <= ras_cnt_reg + CNT_W'(1);
         if (!pins_reg.col_strobe_n)
            col_cnt_reg <= col_cnt_reg + CNT_W'(1);
         unique case (state_reg)
            ST_IDLE: begin
               // A ready already shown is honoured; refresh then waits for that whole access to finish.
               if (take) begin
                  req_ready_reg <= 1'b0;
                  cur_reg       <= req;
                  // Address is set one cycle before the row strobe falls.
                  pins_reg.multiplexed_address_pins <= req.addr[15:8];
                  pins_reg.col_strobe_n <= 1'b1;
                  cnt_reg       <= '0;
                  min_cyc_reg   <= (req.op == DMC_RMW) ? CNT_W'(RWC_CYC) : CNT_W'(RC_CYC);
                  state_reg     <= ST_ROW;
               end else if (ref_pend_reg) begin
                  req_ready_reg <= 1'b0;
                  pins_reg.multiplexed_address_pins <= {1'b0, ref_row_reg};
                  pins_reg.row_strobe_n <= 1'b0;
                  ras_cnt_reg <= '0;
                  cnt_reg     <= '0;
                  state_reg   <= ST_REF_ROW;
               end else begin
                  req_ready_reg <= 1'b1;
               end
            end
            ST_ROW: begin
               pins_reg.row_strobe_n <= 1'b0;
               pins_reg.write_en_n   <= (cur_reg.op != DMC_WRITE);
               pins_reg.data_in      <= cur_reg.wdata;
               ras_cnt_reg <= '0;
               cnt_reg     <= '0;
               state_reg   <= ST_COL;
            end
            ST_COL: begin
               // Column address goes out after the row hold; strobe one cycle later.
               if (cnt_reg == CNT_W'(RAH_CYC - 1))
                  pins_reg.multiplexed_address_pins <= cur_reg.addr[7:0];
               // The row fell on the same edge this state began counting.
               if (cnt_reg >= CNT_W'(RCD_CYC - 1) && cnt_reg >= CNT_W'(RAH_CYC)) begin
                  pins_reg.col_strobe_n <= 1'b0;
                  col_cnt_reg <= '0;
                  cnt_reg     <= '0;
                  state_reg   <= ST_ACCESS;
               end
            end
            ST_ACCESS: begin
               // Sample read data once both access times have passed.
               if (cnt_reg >= CNT_W'(CAC_CYC) && ras_cnt_reg >= CNT_W'(RAS_CYC - 1)
                   && ras_cnt_reg >= CNT_W'((ROW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)) begin
                  if (cur_reg.op != DMC_WRITE) begin
                     rdata_reg       <= data_out;
                     rdata_valid_reg <= (cur_reg.op == DMC_READ);
                  end
                  cnt_reg <= '0;
                  if (cur_reg.op == DMC_RMW) begin
                     state_reg <= ST_WRITE;
                  end else
                     state_reg <= ST_CLOSE;
               end
            end
            ST_WRITE: begin
               // Late write edge keeps the read-write timing defined.
               if (col_cnt_reg >= CNT_W'(CWD_CYC) && ras_cnt_reg >= CNT_W'(RWD_CYC)
                   && pins_reg.write_en_n) begin
                  pins_reg.write_en_n <= 1'b0;
                  cnt_reg <= '0;
               end else if (!pins_reg.write_en_n && cnt_reg >= CNT_W'(WL_CYC)) begin
                  cnt_reg   <= '0;
                  state_reg <= ST_CLOSE;
               end
            end
            ST_CLOSE: begin
               // Write enable has led both rising edges by the lead time.
               if (cnt_reg >= CNT_W'(WL_CYC) || pins_reg.write_en_n) begin
                  pins_reg.col_strobe_n <= 1'b1;
                  cnt_reg <= '0;
                  if (cur_reg.page && req_valid && !ref_pend_reg
                      && req.addr[15:8] == cur_reg.addr[15:8] && req.op != DMC_RMW) begin
                     cur_reg   <= req;
                     state_reg <= ST_PAGE_PRE;
                  end else begin
                     pins_reg.row_strobe_n <= 1'b1;
                     state_reg <= ST_PRECHARGE;
                  end
               end
            end
            ST_PAGE_PRE: begin
               // Page request consumed here; column precharge and page pitch kept.
               req_ready_reg <= (cnt_reg == CNT_W'(0));
               pins_reg.multiplexed_address_pins <= cur_reg.addr[7:0];
               pins_reg.write_en_n <= (cur_reg.op != DMC_WRITE);
               pins_reg.data_in    <= cur_reg.wdata;
               if (cnt_reg >= CNT_W'(CP_CYC) && col_cnt_reg >= CNT_W'(PC_CYC - CP_CYC)) begin
                  pins_reg.col_strobe_n <= 1'b0;
                  col_cnt_reg <= '0;
                  cnt_reg     <= '0;
                  state_reg   <= ST_ACCESS;
               end
            end
            ST_PRECHARGE: begin
               // Row high for precharge and total cycle at least the cycle time.
               pins_reg.write_en_n <= 1'b1;
               if (cnt_reg >= CNT_W'(RP_CYC) && ras_cnt_reg + cnt_reg >= min_cyc_reg) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_REF_ROW: begin
               // Only the row strobe moves; the data output stays off.
               if (cnt_reg >= CNT_W'(RAS_CYC)) begin
                  pins_reg.row_strobe_n <= 1'b1;
                  cnt_reg     <= '0;
                  min_cyc_reg <= CNT_W'(RC_CYC);
                  state_reg   <= ST_PRECHARGE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_col_gated: assert property (@(posedge clock) disable iff (!arst_n)
      !pins_reg.col_strobe_n |-> !pins_reg.row_strobe_n)
      else $error("Column strobe low with row strobe high.");
   a_col_delay: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(state_reg == ST_ACCESS) && $past(state_reg) == ST_COL |->
      ras_cnt_reg >= CNT_W'(RCD_CYC))
      else $error("Column strobe fell too early.");
   a_refresh_only: assert property (@(posedge clock) disable iff (!arst_n)
      state_reg == ST_REF_ROW |-> pins_reg.col_strobe_n)
      else $error("Column strobe moved in refresh.");
   a_ras_width: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(pins_reg.row_strobe_n) |-> $past(ras_cnt_reg) >= CNT_W'(RAS_CYC - 1))
      else $error("Row strobe pulse too short.");
   a_row_pre: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(pins_reg.row_strobe_n) |-> pins_reg.row_strobe_n [*4])
      else $error("Row precharge too short.");
   a_write_edge: assert property (@(posedge clock) disable iff (!arst_n)
      $fell(pins_reg.write_en_n) && !pins_reg.col_strobe_n |->
      col_cnt_reg >= CNT_W'(CWD_CYC) && ras_cnt_reg >= CNT_W'(RWD_CYC))
      else $error("Late write edge too early.");
   a_write_lead: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(pins_reg.col_strobe_n) && $past(!pins_reg.write_en_n) |->
      $past(!pins_reg.write_en_n, 3))
      else $error("Write lead before column rise too short.");
   a_read_setup: assert property (@(posedge clock) disable iff (!arst_n)
      $fell(pins_reg.col_strobe_n) && cur_reg.op != DMC_WRITE |-> pins_reg.write_en_n)
      else $error("Write enable low at read column strobe.");
   a_refresh_due: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(ref_pend_reg) |-> ##[1:40] state_reg == ST_REF_ROW)
      else $error("Refresh request not served in time.");
   c_read: cover property (@(posedge clock) disable iff (!arst_n) rdata_valid_reg);
   c_rmw: cover property (@(posedge clock) disable iff (!arst_n) state_reg == ST_WRITE);
   c_page: cover property (@(posedge clock) disable iff (!arst_n) state_reg == ST_PAGE_PRE);
   c_refresh: cover property (@(posedge clock) disable iff (!arst_n) state_reg == ST_REF_ROW);
endmodule

/* File: test/dmc_mem_model.sv */
// Behavioural model of one 64K x 1 dynamic memory on the controller's pins.
// Assumes strobes come from registers; counts controller timing breaches in viol.
`timescale 1ns/1ps
module dmc_mem_model
   import dmc_pkg::*;
#(
   parameter realtime RET_NS = 2000000.0
) (
   // Memory pins
   input  wire dmc_pins_t pins,
   output logic           data_out,
   // Breach count
   output int             viol
);
   // ---------------------------------------------------------------
   // Cell array and edge times
   // ---------------------------------------------------------------
   logic        mem [65536];
   logic [7:0]  row;
   logic [15:0] a;
   logic        dq, rd, pat, rmw;
   realtime     t_rf, t_rr, t_cf, t_cr, t_wf, t_on;
   realtime     seen [128];

   initial begin
      foreach (mem[i]) mem[i] = 1'b0;
      foreach (seen[i]) seen[i] = 0.0;
      {dq, rd, pat, rmw, viol} = '0;
      t_rf = 0.0;
      t_rr = 0.0;
      t_cf = 0.0;
      t_cr = 0.0;
      t_wf = 0.0;
      t_on = 0.0;
   end

   // Row strobe fall latches the row and counts as a refresh of it.
   always @(negedge pins.row_strobe_n) begin
      if (t_rf > 0 && $realtime - t_rf < (rmw ? 375 : 330)) viol++;
      if (t_rr > 0 && $realtime - t_rr < 120) viol++;
      row = pins.multiplexed_address_pins;
      seen[row[6:0]] = $realtime;
      t_rf = $realtime;
      rmw = 1'b0;
   end

   // Write enable must lead the row strobe rise; row low width is bounded.
   always @(posedge pins.row_strobe_n) begin
      if ($realtime - t_rf > 10000) viol++;
      if (!pins.write_en_n && $realtime - t_wf < 80) viol++;
      t_rr = $realtime;
   end

   // Column strobe is gated by the row strobe.
   always @(negedge pins.col_strobe_n) if (!pins.row_strobe_n) begin
      if (t_cf > t_rf) begin
         if ($realtime - t_cf < 225 || $realtime - t_cr < 80) viol++;
      end else if ($realtime - t_rf < 30 || $realtime - t_rf > 65) viol++;
      t_cf = $realtime;
      a = {row, pins.multiplexed_address_pins};
      rd = pins.write_en_n;
      if (!rd) mem[a] = pins.data_in;
      dq = mem[a];
      t_on = (t_rf + 200 > t_cf + 135) ? t_rf + 200 : t_cf + 135;
   end

   always @(posedge pins.col_strobe_n) begin
      if (!pins.write_en_n && $realtime - t_wf < 80) viol++;
      t_cr = $realtime;
   end

   // A late write enable makes a read-write; bad spacing spoils the output.
   always @(negedge pins.write_en_n) begin
      t_wf = $realtime;
      if (!pins.col_strobe_n && !pins.row_strobe_n && rd) begin
         mem[a] = pins.data_in;
         rmw = 1'b1;
         if ($realtime - t_cf < 95 || $realtime - t_rf < 160) dq = ~dq;
      end
   end

   // Output off shows a toggling level, since the line has no pull.
   always #25 pat = ~pat;
   always #1 data_out = (rd && !pins.col_strobe_n && $realtime >= t_on) ? dq : pat;
endmodule

/* File: test/test_dmc_ctrl.sv */
// Self-checking bench for the dynamic memory controller.
// Assumes the memory model file is compiled before this one.
`timescale 1ns/1ps
module test_dmc_ctrl;
   import dmc_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   localparam int      REF = 60;
   localparam realtime RET = 128.0 * (REF + 30) * 25.0; // Retention scaled with REF.
   logic        clock, arst_n, req_valid, req_ready, rdata_valid, rdata, data_out;
   dmc_req_t    req;
   dmc_pins_t   pins;
   int          err_total, tests_run, cyc, viol;
   logic [31:0] seed, r;
   logic        ref_mem [65536];
   logic        expq [$];
   logic [15:0] ad;

   dmc_ctrl #(.REF_INTERVAL(REF)) dmc_ctrl_inst (.clock(clock), .arst_n(arst_n),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rdata_valid(rdata_valid),
      .rdata(rdata), .pins(pins), .data_out(data_out));
   dmc_mem_model #(.RET_NS(RET)) dmc_mem_model_inst (.pins(pins), .data_out(data_out),
      .viol(viol));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check_bit(string what, logic exp, logic got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_cnt(string what, int exp, int got);
      tests_run++;
      if (got != exp) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Holds the request until taken; the reference memory follows in order.
   task automatic issue(dmc_op_t op, logic [15:0] adr, logic wd, logic pg);
      int n;
      n = 0;
      req_valid = 1'b1;
      req = '{op, adr, wd, pg};
      do begin
         @(negedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      if (n == 300) check_bit("request taken", 1'b1, req_ready);
      @(posedge clock);
      #2;
      if (op == DMC_READ) expq.push_back(ref_mem[adr]);
      else ref_mem[adr] = wd;
   endtask

   // Drops the request and lets one edge pass.
   task automatic idle();
      req_valid = 1'b0;
      @(posedge clock);
      #2;
   endtask

   // ---------------------------------------------------------------
   // Clock, timeout and read data monitor
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         finish_test();
      end
   end

   always @(negedge clock) if (rdata_valid === 1'b1) begin
      if (expq.size() == 0) check_bit("unexpected read data", 1'b0, 1'b1);
      else check_bit("read data", expq.pop_front(), rdata);
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {err_total, tests_run, cyc} = '0;
      seed = 32'h3ADB;
      foreach (ref_mem[i]) ref_mem[i] = 1'b0;
      arst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      repeat (3) @(posedge clock);
      check_bit("row strobe in reset", 1'b1, pins.row_strobe_n);
      #2 arst_n = 1'b1;
      repeat (2) @(posedge clock);
      #2;
      // Address extremes, both data values, write then read back.
      for (int k = 0; k < 4; k++) begin
         ad = k[0] ? 16'hFFFF : 16'h0000;
         issue(DMC_WRITE, ad, k[1], 1'b0);
         idle();
         issue(DMC_READ, ad, 1'b0, 1'b0);
         idle();
      end
      // Read-write returns the old bit and stores the new one.
      issue(DMC_WRITE, 16'h5AA5, 1'b1, 1'b0);
      issue(DMC_RMW, 16'h5AA5, 1'b0, 1'b0);
      idle();
      issue(DMC_READ, 16'h5AA5, 1'b1, 1'b0);
      idle();
      check_bit("old bit kept", 1'b1, rdata);
      wait (expq.size() == 0);
      // Page chains of writes then reads on one row.
      for (int k = 0; k < 4; k++) issue(DMC_WRITE, {8'h3C, 6'h0, k[1:0]}, ~k[0], k < 3);
      for (int k = 0; k < 4; k++) issue(DMC_READ, {8'h3C, 6'h0, k[1:0]}, 1'b0, k < 3);
      idle();
      // Random traffic on a small region, often back to back.
      ad = '0;
      while (cyc < 16000) begin
         r = rnd();
         if (!ad[15]) ad = r[15:0] & 16'h070F;
         else ad[3:0] = r[3:0];
         ad[15] = r[20] & (r[17:16] != 2'd2);
         issue(r[17:16] == 2'd2 ? DMC_RMW : dmc_op_t'(r[16]), {1'b0, ad[14:0]}, r[19],
               ad[15]);
         if (r[22]) idle();
      end
      idle();
      repeat (40) @(posedge clock);
      check_cnt("reads left", 0, expq.size());
      check_cnt("timing breaches", 0, viol);
      for (int k = 0; k < 128; k++)
         check_bit("row refreshed", 1'b1, $realtime - dmc_mem_model_inst.seen[k] <= RET);
      finish_test();
   end
endmodule
